// ==== hdl/thermal_pkg.sv ====
// Behaviour
// - Upper switching frequency settable 2 to 16 kHz
// - Upper default 2 kHz group 1, else 4
// - Active frequency stays within minimum and upper
// - Minimum not below upper disables automatic reduction
// - Reduce above switch-off limit plus reduction offset
// - Raise stepwise once 5 degrees below limit
// - Reduce above 87.5 percent of overload current
// - Raise below next higher step reference current
// - Fan switch-on temperature settable 0 to 60
// - Mains present and hot turns fan on
// - Unit on, enable plus start turns fan on always
// - Fan off 5 below or enable lost
// - Fan minimum on-time one minute from start
// - Output function 43 drives external fan alike; code turns it on when hot without mains
package thermal_pkg;

   localparam longint CLK_HZ          = 50_000_000;
   localparam longint EVAL_PERIOD_US  = 1000;
   localparam longint EVAL_CYC        = EVAL_PERIOD_US * CLK_HZ / 1_000_000;
   localparam longint FAN_MIN_ON_S    = 60;
   localparam longint FAN_MIN_ON_CYC  = FAN_MIN_ON_S * CLK_HZ;

   // Register byte offsets
   localparam logic [4:0] OFS_FSW_MAX  = 5'h00;
   localparam logic [4:0] OFS_FSW_MIN  = 5'h04;
   localparam logic [4:0] OFS_RED_LIM  = 5'h08;
   localparam logic [4:0] OFS_FAN_TEMP = 5'h0c;
   localparam logic [4:0] OFS_CTRL     = 5'h10;
   localparam logic [4:0] OFS_STATUS   = 5'h14;

   // Field positions
   localparam int CTRL_ICL_FULL_BIT = 0;
   localparam int CTRL_DOUT_LSB     = 8;
   localparam int ST_FAN_INT_BIT    = 8;
   localparam int ST_FAN_EXT_BIT    = 9;
   localparam int ST_AUTO_BIT       = 10;
   localparam int ST_TEMP_RED_BIT   = 11;
   localparam int ST_CUR_RED_BIT    = 12;

   // Limits and reset values
   localparam logic [4:0]        KHZ_LOW          = 5'h02;
   localparam logic [4:0]        KHZ_HIGH         = 5'h10;
   localparam logic [4:0]        KHZ_MAX_GRP1     = 5'h02;
   localparam logic [4:0]        KHZ_MAX_OTHER    = 5'h04;
   localparam logic [4:0]        RST_FSW_MIN      = 5'h02;
   localparam logic [3:0]        CFG_GROUP_ONE    = 4'h1;
   localparam logic signed [7:0] RED_LIM_LOW      = -8'sd25;
   localparam logic signed [7:0] RED_LIM_HIGH     = 8'sh00;
   localparam logic signed [7:0] RST_RED_LIM      = -8'sd4;
   localparam logic [7:0]        FAN_TEMP_HIGH    = 8'h3c;
   localparam logic [7:0]        RST_FAN_TEMP     = 8'h00;
   localparam logic [5:0]        DOUT_EXT_FAN     = 6'h2b;
   localparam logic signed [9:0] HYST_DEG         = 10'sd5;

   typedef struct packed {
      logic [4:0]        max_khz;
      logic [4:0]        min_khz;
      logic signed [7:0] red_lim;
      logic [7:0]        fan_temp;
      logic              icl_full;
      logic [5:0]        dout_func;
      logic              strap_done;
      logic [4:0]        fsw_khz;
      logic [31:0]       eval_cnt;
      logic              temp_red;
      logic              cur_red;
      logic              fan_hot;
      logic [15:0]       rd_data;
   } therm_state_t;

   typedef struct packed {
      logic        on;
      logic [31:0] cnt;
   } fan_state_t;

   typedef struct packed {
      logic signed [7:0] heatsink;
      logic signed [7:0] off_limit;
   } temp_in_t;

   typedef struct packed {
      logic [15:0] output_i;
      logic [15:0] overload_60s;
      logic [15:0] ref_next_up;
   } current_in_t;

   typedef struct packed {
      logic mains_present;
      logic unit_on;
      logic ctrl_enable;
      logic start_cw;
      logic start_ccw;
   } cmd_in_t;

endpackage

// ==== hdl/fan_hold.sv ====
`timescale 1ns/1ps
module fan_hold
#(
   parameter logic [31:0] MIN_ON_CYCLES = 32'h0000_0010
)
(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic want,
   output logic      fan_on
);
   import thermal_pkg::*;

   fan_state_t s_q;
   fan_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (!s_q.on)
      begin
         if (want)
         begin
            s_d.on  = 1'b1;
            s_d.cnt = 32'h0000_0001;
         end
      end
      else
      begin
         if (s_q.cnt < MIN_ON_CYCLES)
            s_d.cnt = s_q.cnt + 32'h0000_0001;
         else if (!want)
            s_d.on = 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign fan_on = s_q.on;

endmodule

// ==== hdl/thermal_ctrl.sv ====
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module thermal_ctrl
#(
   parameter logic [31:0] EVAL_CYCLES       = 32'(thermal_pkg::EVAL_CYC),
   parameter logic [31:0] FAN_MIN_ON_CYCLES = 32'(thermal_pkg::FAN_MIN_ON_CYC)
)
(
   input  wire logic                      clk_sys,
   input  wire logic                      reset,
   input  wire logic [3:0]                config_group,
   input  wire thermal_pkg::temp_in_t     temp_in,
   input  wire thermal_pkg::current_in_t  current_in,
   input  wire thermal_pkg::cmd_in_t      cmd_in,
   input  wire logic [4:0]                addr,
   input  wire logic [15:0]               wr_data,
   input  wire logic                      wr_stb,
   input  wire logic                      rd_stb,
   output logic [15:0]                    rd_data,
   output logic [4:0]                     fsw_khz,
   output logic                           fan_int_on,
   output logic                           fan_ext_on
);
   import thermal_pkg::*;

   therm_state_t s_q;
   therm_state_t s_d;

   logic              fan_int_want;
   logic              fan_ext_want;
   logic              start_req;
   logic              auto_en;
   logic              eval_tick;
   logic signed [9:0] temp_s;
   logic signed [9:0] red_thr;
   logic signed [9:0] fan_thr;
   logic [15:0]       cur_thr;
   logic              temp_over;
   logic              temp_cool;
   logic              cur_over;
   logic              cur_low;
   logic              cur_active;
   logic [4:0]        eff_min;

   ////////////////////////////////////////////////////////////////////////
   // Setting clamps

   function automatic logic [4:0] clamp_khz(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h00;
      if (v < 16'(KHZ_LOW))
         r = KHZ_LOW;
      else if (v > 16'(KHZ_HIGH))
         r = KHZ_HIGH;
      else
         // Odd values snap down so every setting lands on a step
         r = v[4:0] & 5'h1e;
      return r;
   endfunction

   function automatic logic signed [7:0] clamp_red(input logic [15:0] v);
      logic signed [7:0] t;
      logic signed [7:0] r;
      t = v[7:0];
      r = t;
      if (t < RED_LIM_LOW)
         r = RED_LIM_LOW;
      else if (t > RED_LIM_HIGH)
         r = RED_LIM_HIGH;
      return r;
   endfunction

   function automatic logic [7:0] clamp_fan(input logic [15:0] v);
      logic [7:0] r;
      r = v[7:0];
      if (v > 16'(FAN_TEMP_HIGH))
         r = FAN_TEMP_HIGH;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Measurement decisions

   always_comb
   begin
      temp_s    = 10'(temp_in.heatsink);
      red_thr   = 10'(temp_in.off_limit) + 10'(s_q.red_lim);
      temp_over = temp_s > red_thr;
      temp_cool = temp_s <= (red_thr - HYST_DEG);
      cur_thr   = current_in.overload_60s - (current_in.overload_60s >> 3);
      cur_active = s_q.icl_full;
      cur_over  = cur_active && (current_in.output_i > cur_thr);
      cur_low   = !cur_active ||
                  (current_in.output_i < current_in.ref_next_up);
      // Disable reduction if min not below max
      auto_en   = s_q.min_khz < s_q.max_khz;
      eff_min   = auto_en ? s_q.min_khz : s_q.max_khz;
      eval_tick = s_q.eval_cnt >= (EVAL_CYCLES - 32'h0000_0001);
      fan_thr   = 10'($signed({2'b00, s_q.fan_temp}));
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_d = s_q;

      // Capture upper default from configuration group
      if (!s_q.strap_done)
      begin
         s_d.strap_done = 1'b1;
         s_d.max_khz    = (config_group == CFG_GROUP_ONE) ?
                          KHZ_MAX_GRP1 : KHZ_MAX_OTHER;
         s_d.fsw_khz    = s_d.max_khz;
      end

      if (wr_stb)
      begin
         case (addr)
            OFS_FSW_MAX:  s_d.max_khz  = clamp_khz(wr_data);
            OFS_FSW_MIN:  s_d.min_khz  = clamp_khz(wr_data);
            OFS_RED_LIM:  s_d.red_lim  = clamp_red(wr_data);
            OFS_FAN_TEMP: s_d.fan_temp = clamp_fan(wr_data);
            OFS_CTRL:
            begin
               s_d.icl_full  = wr_data[CTRL_ICL_FULL_BIT];
               s_d.dout_func = wr_data[CTRL_DOUT_LSB +: 6];
            end
            default: ;
         endcase
      end

      s_d.eval_cnt = eval_tick ? 32'h0000_0000 :
                     s_q.eval_cnt + 32'h0000_0001;
      s_d.temp_red = temp_over;
      s_d.cur_red  = cur_over;

      if (s_q.strap_done)
      begin
         if (s_q.fsw_khz > s_q.max_khz || !auto_en)
            s_d.fsw_khz = s_q.max_khz;
         else if (s_q.fsw_khz < eff_min)
            s_d.fsw_khz = eff_min;
         else if (eval_tick)
         begin
            if ((temp_over || cur_over) && s_q.fsw_khz > eff_min)
               s_d.fsw_khz = s_q.fsw_khz - 5'h02;
            else if (!temp_over && !cur_over && temp_cool && cur_low &&
                     s_q.fsw_khz < s_q.max_khz)
               s_d.fsw_khz = s_q.fsw_khz + 5'h02;
         end
      end

      if (temp_s > fan_thr)
         s_d.fan_hot = 1'b1;
      else if (temp_s <= fan_thr - HYST_DEG)
         s_d.fan_hot = 1'b0;

      s_d.rd_data = 16'h0000;
      if (rd_stb)
      begin
         case (addr)
            OFS_FSW_MAX:  s_d.rd_data = {11'h000, s_q.max_khz};
            OFS_FSW_MIN:  s_d.rd_data = {11'h000, s_q.min_khz};
            OFS_RED_LIM:  s_d.rd_data = {8'h00, s_q.red_lim};
            OFS_FAN_TEMP: s_d.rd_data = {8'h00, s_q.fan_temp};
            OFS_CTRL:     s_d.rd_data = {2'b00, s_q.dout_func,
                                         7'h00, s_q.icl_full};
            OFS_STATUS:
            begin
               s_d.rd_data[4:0]             = s_q.fsw_khz;
               s_d.rd_data[ST_FAN_INT_BIT]  = fan_int_on;
               s_d.rd_data[ST_FAN_EXT_BIT]  = fan_ext_on;
               s_d.rd_data[ST_AUTO_BIT]     = auto_en;
               s_d.rd_data[ST_TEMP_RED_BIT] = s_q.temp_red;
               s_d.rd_data[ST_CUR_RED_BIT]  = s_q.cur_red;
            end
            default: s_d.rd_data = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         s_q            <= '0;
         s_q.max_khz    <= KHZ_MAX_OTHER;
         s_q.min_khz    <= RST_FSW_MIN;
         s_q.red_lim    <= RST_RED_LIM;
         s_q.fan_temp   <= RST_FAN_TEMP;
         s_q.fsw_khz    <= KHZ_MAX_OTHER;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Fans

   always_comb
   begin
      start_req    = cmd_in.unit_on && cmd_in.ctrl_enable &&
                     (cmd_in.start_cw || cmd_in.start_ccw);
      fan_int_want = (cmd_in.mains_present && s_q.fan_hot) || start_req;
      fan_ext_want = (s_q.dout_func == DOUT_EXT_FAN) &&
                     (start_req || s_q.fan_hot);
   end

   fan_hold
   #(
      .MIN_ON_CYCLES (FAN_MIN_ON_CYCLES)
   )
   u_fan_int
   (
      .clk_sys (clk_sys),
      .reset   (reset),
      .want    (fan_int_want),
      .fan_on  (fan_int_on)
   );

   // Shares the one-minute hold but keeps its own timer
   fan_hold
   #(
      .MIN_ON_CYCLES (FAN_MIN_ON_CYCLES)
   )
   u_fan_ext
   (
      .clk_sys (clk_sys),
      .reset   (reset),
      .want    (fan_ext_want),
      .fan_on  (fan_ext_on)
   );

   assign rd_data = s_q.rd_data;
   assign fsw_khz = s_q.fsw_khz;

endmodule

// ==== tb/sense_model.sv ====
`timescale 1ns/1ps
module sense_model
#(
   parameter logic signed [7:0] OFF_LIM = 8'sh50,
   parameter logic [15:0]       OVL     = 16'h0320,
   parameter logic [15:0]       REF_UP  = 16'h01f4
)
(
   input  wire logic                     clk_sys,
   input  wire logic signed [7:0]        hs_set,
   input  wire logic [15:0]              i_set,
   output thermal_pkg::temp_in_t         temp_in,
   output thermal_pkg::current_in_t      current_in
);
   // One cycle of measurement latency, like a sampled sensor
   always_ff @(posedge clk_sys)
   begin
      temp_in    <= {hs_set, OFF_LIM};
      current_in <= {i_set, OVL, REF_UP};
   end
endmodule

// ==== tb/thermal_ctrl_chk.sv ====
`timescale 1ns/1ps
module thermal_ctrl_chk
#(
   parameter logic [31:0] EVAL_CYCLES       = 32'h0000_0008,
   parameter logic [31:0] FAN_MIN_ON_CYCLES = 32'h0000_0014
)
(
   input wire logic                 clk_sys,
   input wire logic                 reset,
   input wire thermal_pkg::cmd_in_t cmd_in,
   input wire logic                 wr_stb,
   input wire logic                 rd_stb,
   input wire logic [15:0]          rd_data,
   input wire logic [4:0]           fsw_khz,
   input wire logic                 fan_int_on,
   input wire logic                 fan_ext_on
);
   import thermal_pkg::*;
   logic [7:0]  quiet_q;
   logic [7:0]  since_q;
   logic [4:0]  last_q;
   logic [31:0] on_q;
   logic [31:0] ext_q;
   // Writes may clamp the window by a jump, so step checks wait
   always_ff @(posedge clk_sys)
   begin
      quiet_q <= (reset || wr_stb) ? 8'h00 : quiet_q + {7'h0, ~&quiet_q};
      since_q <= (fsw_khz != last_q) ? 8'h00 : since_q + {7'h0, ~&since_q};
      last_q  <= fsw_khz;
      on_q    <= (reset || !fan_int_on) ? 32'h0 : on_q + 32'h1;
      ext_q   <= (reset || !fan_ext_on) ? 32'h0 : ext_q + 32'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_start;
      cmd_in.unit_on && cmd_in.ctrl_enable
         && (cmd_in.start_cw || cmd_in.start_ccw);
   endsequence
   sequence s_step;
      fsw_khz == last_q + 5'h02 || fsw_khz + 5'h02 == last_q;
   endsequence
   AST_FSW_RANGE: assert property (fsw_khz >= KHZ_LOW
      && fsw_khz <= KHZ_HIGH && !fsw_khz[0]) else $error("fsw out of range");
   AST_FAN_START: assert property (s_start |=> fan_int_on)
      else $error("fan not started");
   AST_FAN_MIN_ON: assert property ($fell(fan_int_on)
      |-> on_q >= FAN_MIN_ON_CYCLES) else $error("fan on too short");
   AST_EXT_MIN_ON: assert property ($fell(fan_ext_on)
      |-> ext_q >= FAN_MIN_ON_CYCLES) else $error("ext fan on too short");
   AST_ONE_STEP: assert property (quiet_q > 8'h0c
      && fsw_khz != last_q |-> s_step) else $error("fsw jumped");
   AST_TICK_GAP: assert property (quiet_q > 8'h0c && fsw_khz != last_q
      |-> since_q >= EVAL_CYCLES - 32'h1) else $error("steps too close");
   AST_RD_IDLE: assert property (!rd_stb |=> rd_data == 16'h0000)
      else $error("read data outside slot");
   AST_RESET_OUT: assert property ($fell(reset) |-> fsw_khz == 5'h04
      && !fan_int_on && !fan_ext_on) else $error("bad reset outputs");
endmodule
bind thermal_ctrl thermal_ctrl_chk #(.EVAL_CYCLES(EVAL_CYCLES),
   .FAN_MIN_ON_CYCLES(FAN_MIN_ON_CYCLES)) u_thermal_ctrl_chk (
   .clk_sys(clk_sys), .reset(reset), .cmd_in(cmd_in), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rd_data(rd_data), .fsw_khz(fsw_khz),
   .fan_int_on(fan_int_on), .fan_ext_on(fan_ext_on));

// ==== tb/thermal_ctrl_test.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module thermal_ctrl_test;
   import thermal_pkg::*;
   logic              clk_sys = 1'b0;
   logic              reset = 1'b1;
   logic              wr_stb = 1'b0;
   logic              rd_stb = 1'b0;
   logic [3:0]        config_group = 4'h1;
   logic [4:0]        addr = 5'h00;
   logic [15:0]       wr_data = 16'h0;
   logic [15:0]       i_set = 16'h0;
   logic signed [7:0] hs_set = 8'sh00;
   cmd_in_t           cmd_in = '0;
   logic [15:0]       rd_data;
   logic [4:0]        fsw_khz;
   logic              fan_int_on;
   logic              fan_ext_on;
   temp_in_t          temp_in;
   current_in_t       current_in;
   int                fails = 0;
   int                checks_done = 0;
   initial forever #10 clk_sys = ~clk_sys;
   thermal_ctrl #(.EVAL_CYCLES(32'h8), .FAN_MIN_ON_CYCLES(32'h14))
   u_thermal_ctrl (.clk_sys(clk_sys), .reset(reset),
      .config_group(config_group), .temp_in(temp_in),
      .current_in(current_in), .cmd_in(cmd_in), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data), .fsw_khz(fsw_khz), .fan_int_on(fan_int_on),
      .fan_ext_on(fan_ext_on));
   sense_model u_sense_model (.clk_sys(clk_sys), .hs_set(hs_set),
      .i_set(i_set), .temp_in(temp_in), .current_in(current_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a, logic [15:0] e, string n);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      // Data stand only this cycle; take them at its closing edge
      @(posedge clk_sys);
      `CHK(n, e, rd_data)
   endtask
   task automatic wait_fsw(logic [4:0] e, string n);
      int k = 0;
      while (fsw_khz !== e && k < 400)
      begin
         @(posedge clk_sys);
         k++;
      end
      `CHK(n, e, fsw_khz)
   endtask
   task automatic t_strap(logic [3:0] g, logic [4:0] e);
      reset <= 1'b1;
      config_group <= g;
      cyc(8);
      reset <= 1'b0;
      cyc(3);
      `CHK("strap", e, fsw_khz)
      rd(OFS_FSW_MIN, 16'h0002, "min reset");
      rd(OFS_RED_LIM, 16'h00fc, "limit reset");
      rd(OFS_FAN_TEMP, 16'h0000, "fan temp reset");
      rd(5'h1c, 16'h0000, "unmapped");
      $display("strap test done");
   endtask
   task automatic t_regs();
      logic [4:0]  a[4] = '{OFS_FSW_MAX, OFS_FSW_MAX, OFS_RED_LIM, OFS_FAN_TEMP};
      logic [15:0] d[4] = '{16'h0011, 16'h0001, 16'h00e2, 16'h0046};
      logic [15:0] e[4] = '{16'h0010, 16'h0002, 16'h00e7, 16'h003c};
      for (int i = 0; i < 4; i++)
      begin
         wr(a[i], d[i]);
         rd(a[i], e[i], "clamped setting");
      end
      $display("register test done");
   endtask
   task automatic t_temp();
      wr(OFS_FSW_MAX, 16'h0010);
      wr(OFS_FSW_MIN, 16'h0004);
      wr(OFS_RED_LIM, 16'h00fc);
      hs_set <= 8'sd70;
      wait_fsw(5'h10, "raise to upper");
      hs_set <= 8'sd77;
      wait_fsw(5'h04, "reduce to min");
      cyc(40);
      `CHK("hold at min", 5'h04, fsw_khz)
      hs_set <= 8'sd72;
      cyc(40);
      `CHK("hysteresis", 5'h04, fsw_khz)
      hs_set <= 8'sd71;
      wait_fsw(5'h10, "raise again");
      wr(OFS_FSW_MAX, 16'h0008);
      wr(OFS_FSW_MIN, 16'h000a);
      hs_set <= 8'sd90;
      cyc(40);
      `CHK("auto off", 5'h08, fsw_khz)
      rd(OFS_STATUS, 16'h0808, "status temp");
      $display("temperature test done");
   endtask
   task automatic t_current();
      wr(OFS_FSW_MAX, 16'h0010);
      wr(OFS_FSW_MIN, 16'h0002);
      wr(OFS_CTRL, 16'h0001);
      hs_set <= 8'sd0;
      wait_fsw(5'h10, "raise at low current");
      i_set <= 16'd700;
      cyc(40);
      `CHK("no reduce at limit", 5'h10, fsw_khz)
      i_set <= 16'd701;
      wait_fsw(5'h02, "reduce on current");
      rd(OFS_STATUS, 16'h1402, "status current");
      i_set <= 16'd500;
      cyc(40);
      `CHK("no raise at ref", 5'h02, fsw_khz)
      i_set <= 16'd499;
      wait_fsw(5'h10, "raise below ref");
      i_set <= 16'd0;
      $display("current test done");
   endtask
   task automatic t_fan();
      wr(OFS_FAN_TEMP, 16'h001e);
      wr(OFS_CTRL, 16'h2b00);
      cmd_in.mains_present <= 1'b1;
      hs_set <= 8'sd31;
      cyc(4);
      `CHK("fan hot", 2'b11, {fan_int_on, fan_ext_on})
      hs_set <= 8'sd26;
      cyc(40);
      `CHK("fan hyst", 1'b1, fan_int_on)
      hs_set <= 8'sd25;
      cyc(40);
      `CHK("fan cool", 2'b00, {fan_int_on, fan_ext_on})
      hs_set <= 8'sd0;
      cmd_in.unit_on <= 1'b1;
      cmd_in.ctrl_enable <= 1'b1;
      cmd_in.start_ccw <= 1'b1;
      cyc(2);
      cmd_in.ctrl_enable <= 1'b0;
      `CHK("fan start", 2'b11, {fan_int_on, fan_ext_on})
      cyc(10);
      `CHK("fan min on", 1'b1, fan_int_on)
      cyc(15);
      `CHK("fan off", 2'b00, {fan_int_on, fan_ext_on})
      wr(OFS_CTRL, 16'h0000);
      cmd_in.start_cw <= 1'b1;
      cmd_in.ctrl_enable <= 1'b1;
      cyc(3);
      `CHK("no ext fan", 2'b10, {fan_int_on, fan_ext_on})
      cmd_in <= '0;
      $display("fan test done");
   endtask
   task automatic complete_run();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Whole plan takes about 700 cycles
   initial
   begin
      #400000;
      fails++;
      complete_run();
   end
   initial
   begin
      t_strap(4'h4, KHZ_MAX_OTHER);
      t_strap(4'h1, KHZ_MAX_GRP1);
      t_regs();
      t_temp();
      t_current();
      t_fan();
      complete_run();
   end
endmodule
